// file: aop_defines.svh
`ifndef AOP_DEFINES_SVH
`define AOP_DEFINES_SVH

// ********************
// Register map
// ********************
`define AOP_OFF_CTRL 12'h000
`define AOP_OFF_STATUS 12'h004
`define AOP_OFF_RESULT 12'h008
`define AOP_OFF_CODED 12'h00c

// ********************
// Control field positions
// ********************
`define AOP_CTRL_BYTE_ORDER 0
`define AOP_CTRL_CODING 1
`define AOP_CTRL_PORT_TYPE 2
`define AOP_CTRL_CLK_SRC 3
`define AOP_CTRL_RD_TIMING 4
`define AOP_CTRL_W 5
`define AOP_CTRL_RESET 5'h02

// ********************
// Status field positions
// ********************
`define AOP_ST_DIV_LO 0
`define AOP_ST_BUSY 2
`define AOP_ST_SERIAL 3
`define AOP_ST_MASTER 4
`define AOP_ST_RAC 5
`define AOP_ST_DURING 6
`define AOP_ST_VALID 7

// ********************
// Serial clock timing
// ********************
`define AOP_CLK_NS 10
`define AOP_SCLK_MIN_NS_0 25
`define AOP_SCLK_MIN_NS_1 50
`define AOP_SCLK_MIN_NS_2 100
`define AOP_SCLK_MIN_NS_3 200
`define AOP_NS2CYC(ns) (((ns) + `AOP_CLK_NS - 1) / `AOP_CLK_NS)

`endif

// file: aop_pkg.sv
package aop_pkg;

  // Static port selects, as software sets them
  typedef struct packed {
    logic read_timing;
    logic clock_source;
    logic port_type;
    logic coding;
    logic byte_order;
  } aop_ctrl_t;

  // One pin of the data bus: drive value and enable
  typedef struct packed {
    logic o;
    logic oe;
  } aop_pin_t;

  // Shifter states, Gray along idle -> shift -> idle
  typedef enum logic [1:0] {
    AOP_IDLE = 2'b00,
    AOP_SHIFT = 2'b01
  } aop_state_t;

endpackage

// file: aop_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "aop_defines.svh"

module aop_shifter #(
  parameter int WIDTH = 16,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic start_i,
  input wire logic [WIDTH-1:0] word_i,
  input wire logic ext_clk_i,
  input wire logic sclk_ext_i,
  input wire logic [CNT_W-1:0] period_i,
  // Serial side
  output logic busy_o,
  output logic sclk_o,
  output logic sdo_o
);

  localparam int BIT_W = $clog2(WIDTH + 1);

  aop_pkg::aop_state_t state_q, state_d;
  logic [WIDTH-1:0] sh_q, sh_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [BIT_W-1:0] bits_q, bits_d;
  logic sclk_q, sclk_d;
  logic ext_prev_q, ext_prev_d;
  logic step;

  // ********************
  // Next state
  // ********************
  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    sclk_d = 1'b0;
    ext_prev_d = sclk_ext_i;
    step = 1'b0;
    case (state_q)
      aop_pkg::AOP_IDLE: begin
        if (start_i) begin
          state_d = aop_pkg::AOP_SHIFT;
          sh_d = word_i;
          cnt_d = '0;
          bits_d = '0;
        end
      end
      aop_pkg::AOP_SHIFT: begin
        if (ext_clk_i) begin
          // Host clock: next bit after its falling edge
          step = ext_prev_q & ~sclk_ext_i;
        end else begin
          // Low half then high half of each bit period
          sclk_d = (cnt_q >= (period_i >> 1));
          step = (cnt_q == period_i - 1'b1);
          cnt_d = step ? '0 : cnt_q + 1'b1;
        end
        if (step) begin
          sh_d = {sh_q[WIDTH-2:0], 1'b0};
          bits_d = bits_q + 1'b1;
          if (bits_q == BIT_W'(WIDTH - 1)) begin
            state_d = aop_pkg::AOP_IDLE;
          end
        end
      end
      default: begin
        state_d = aop_pkg::AOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= aop_pkg::AOP_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
      bits_q <= '0;
      sclk_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      sclk_q <= sclk_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  assign busy_o = (state_q == aop_pkg::AOP_SHIFT);
  assign sclk_o = sclk_q;
  assign sdo_o = sh_q[WIDTH-1];

endmodule
`default_nettype wire

// file: aop_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "aop_defines.svh"

// Contract
// - Byte order low puts the low result byte on lines 7..0 and the high on 15..8; high swaps.
// - Coding high gives straight binary; coding low inverts the top bit for two's complement.
// - Port type low enables the parallel bus; high enables serial mode reusing bus pins.
// - Bus bits 0 and 1 float in serial mode and carry result bits 0 and 1 in parallel mode.
// - In parallel mode bus pins 2 and 3 carry result bits 2 and 3.
// - Pins 2 and 3 are serial clock divider inputs only in serial master read-after-convert.
// - In every other serial mode pins 2 and 3 float and are not used as divider inputs.
// - In parallel mode bus pin 4 carries result bit 4.
// - In serial mode clock source low drives the internal clock out; high follows a host clock.
// - With the internal clock, read timing high shifts during conversion; low waits for the end.
// - Divider codes 00, 01, 10, 11 set the least serial clock period to 25, 50, 100, 200 ns.

module aop_port #(
  parameter int WIDTH = 16,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic [WIDTH-1:0] result_i,
  // Data bus pins
  input wire logic [WIDTH-1:0] bus_i,
  output logic [WIDTH-1:0] bus_o,
  output logic [WIDTH-1:0] bus_oe_o,
  // Serial pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o
);

  localparam logic [CNT_W-1:0] PER0 = CNT_W'(`AOP_NS2CYC(`AOP_SCLK_MIN_NS_0));
  localparam logic [CNT_W-1:0] PER1 = CNT_W'(`AOP_NS2CYC(`AOP_SCLK_MIN_NS_1));
  localparam logic [CNT_W-1:0] PER2 = CNT_W'(`AOP_NS2CYC(`AOP_SCLK_MIN_NS_2));
  localparam logic [CNT_W-1:0] PER3 = CNT_W'(`AOP_NS2CYC(`AOP_SCLK_MIN_NS_3));
  localparam int HB = WIDTH / 2;

  // ********************
  // Declarations
  // ********************
  aop_pkg::aop_ctrl_t ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d;
  logic [WIDTH-1:0] raw_q, raw_d;
  logic valid_q, valid_d;
  logic [WIDTH-1:0] coded;
  logic [WIDTH-1:0] placed;
  logic [WIDTH-1:0] out_q, out_d;
  logic [WIDTH-1:0] oe_q, oe_d;
  logic [1:0] div_q, div_d;
  logic [CNT_W-1:0] per_q, per_d;
  logic sclk_oe_q, sclk_oe_d;
  logic sdo_oe_q, sdo_oe_d;
  logic serial;
  logic master;
  logic rac;
  logic during;
  logic start;
  logic [WIDTH-1:0] start_word;
  logic busy;
  logic int_sclk;
  logic sdo;
  logic setup;
  logic access;
  logic [31:0] status;

  // ********************
  // Mode decode
  // ********************
  assign serial = ctrl_q.port_type;
  assign master = serial & ~ctrl_q.clock_source;
  assign rac = master & ~ctrl_q.read_timing;
  assign during = master & ctrl_q.read_timing;

  // ********************
  // Result formatting
  // ********************
  // Coding first, so the inverted bit follows the high byte when swapped
  always_comb begin
    coded = raw_q;
    coded[WIDTH-1] = raw_q[WIDTH-1] ^ ~ctrl_q.coding;
    if (ctrl_q.byte_order) begin
      placed = {coded[HB-1:0], coded[WIDTH-1:HB]};
    end else begin
      placed = coded;
    end
  end

  always_comb begin
    raw_d = raw_q;
    valid_d = valid_q;
    if (conv_done_i) begin
      raw_d = result_i;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      raw_q <= '0;
      valid_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      valid_q <= valid_d;
    end
  end

  // ********************
  // Bus pins
  // ********************
  // All bus pins float in serial mode and drive the placed word in parallel mode
  always_comb begin
    out_d = placed;
    if (serial) begin
      oe_d = '0;
    end else begin
      oe_d = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
      oe_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign bus_o = out_q;
  assign bus_oe_o = oe_q;

  // ********************
  // Serial clock divider
  // ********************
  // Divider pins are only looked at in read-after-convert; otherwise last code holds
  always_comb begin
    div_d = div_q;
    if (rac) begin
      div_d = bus_i[3:2];
    end
    case (div_q)
      2'b00: per_d = PER0;
      2'b01: per_d = PER1;
      2'b10: per_d = PER2;
      default: per_d = PER3;
    endcase
    if (!rac) begin
      per_d = PER0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 2'b00;
      per_q <= PER0;
    end else begin
      div_q <= div_d;
      per_q <= per_d;
    end
  end

  // ********************
  // Serial start
  // ********************
  // During conversion the previous word goes out; after it, the fresh one
  always_comb begin
    start = 1'b0;
    start_word = coded;
    if (serial && !busy) begin
      if (during) begin
        start = conv_start_i & valid_q;
      end else begin
        start = conv_done_i;
        start_word = result_i;
        start_word[WIDTH-1] = result_i[WIDTH-1] ^ ~ctrl_q.coding;
      end
    end
  end

  aop_shifter #(
    .WIDTH(WIDTH),
    .CNT_W(CNT_W)
  ) u_shifter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start),
    .word_i(start_word),
    .ext_clk_i(ctrl_q.clock_source),
    .sclk_ext_i(sclk_i),
    .period_i(per_q),
    .busy_o(busy),
    .sclk_o(int_sclk),
    .sdo_o(sdo)
  );

  always_comb begin
    sclk_oe_d = master;
    sdo_oe_d = serial;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sclk_oe_q <= sclk_oe_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  assign sclk_o = int_sclk;
  assign sclk_oe_o = sclk_oe_q;
  assign serial_result_out_o = sdo;
  assign serial_result_out_oe_o = sdo_oe_q;

  // ********************
  // APB slave
  // ********************
  // Read data is caught in the setup cycle so the access needs no wait
  assign setup = psel & ~penable;
  assign access = psel & penable;

  always_comb begin
    status = '0;
    status[`AOP_ST_DIV_LO +: 2] = div_q;
    status[`AOP_ST_BUSY] = busy;
    status[`AOP_ST_SERIAL] = serial;
    status[`AOP_ST_MASTER] = master;
    status[`AOP_ST_RAC] = rac;
    status[`AOP_ST_DURING] = during;
    status[`AOP_ST_VALID] = valid_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    if (setup) begin
      rdata_d = '0;
      slverr_d = 1'b0;
      if (paddr == `AOP_OFF_CTRL) begin
        rdata_d[`AOP_CTRL_W-1:0] = ctrl_q;
      end else if (paddr == `AOP_OFF_STATUS) begin
        rdata_d = status;
        slverr_d = pwrite;
      end else if (paddr == `AOP_OFF_RESULT) begin
        rdata_d[WIDTH-1:0] = placed;
        slverr_d = pwrite;
      end else if (paddr == `AOP_OFF_CODED) begin
        rdata_d[WIDTH-1:0] = coded;
        slverr_d = pwrite;
      end else begin
        slverr_d = 1'b1;
      end
    end
    if (access && pwrite && paddr == `AOP_OFF_CTRL) begin
      ctrl_d = pwdata[`AOP_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `AOP_CTRL_RESET;
      rdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = access;
  assign pslverr = access & slverr_q;

endmodule
`default_nettype wire

// file: aop_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aop_port_monitor #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Observed ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic [WIDTH-1:0] result_i,
  input wire logic [WIDTH-1:0] bus_i,
  input wire logic [WIDTH-1:0] bus_o,
  input wire logic [WIDTH-1:0] bus_oe_o,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic serial_result_out_o,
  input wire logic serial_result_out_oe_o
);
  logic [4:0] ctl_q;
  logic [15:0] raw_q;
  logic [15:0] cod;
  logic [15:0] fmt;
  logic [5:0] gap_q;
  logic [5:0] per;
  logic mst;
  logic have_q;
  assign cod = raw_q ^ {~ctl_q[1], 15'h0000};
  assign fmt = ctl_q[0] ? {cod[7:0], cod[15:8]} : cod;
  assign mst = ctl_q[2] & ~ctl_q[3];
  // Divider pins only count in read-after-convert
  assign per = ctl_q[4] ? 6'd3 : bus_i[3] ? (bus_i[2] ? 6'd20 : 6'd10) : (bus_i[2] ? 6'd5 : 6'd3);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= 5'h02;
      raw_q <= 16'h0000;
      have_q <= 1'b0;
      gap_q <= 6'h3f;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h000) begin
        ctl_q <= pwdata[4:0];
      end
      if (conv_done_i) begin
        raw_q <= result_i;
        have_q <= 1'b1;
      end
      if ($rose(sclk_o)) begin
        gap_q <= 6'h01;
      end else if (gap_q != 6'h3f) begin
        gap_q <= gap_q + 6'h01;
      end
    end
  end
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Registered outputs lag the reset release by two edges
  sequence settled_s;
    $past(rst_n_i) && $past(rst_n_i, 2);
  endsequence
  fmt_par_a: assert property (settled_s ##0 bus_oe_o[0] |-> bus_o == $past(fmt))
    else $error("parallel word wrong");
  oe_mode_a: assert property (settled_s |-> bus_oe_o == {WIDTH{~$past(ctl_q[2])}})
    else $error("bus enables wrong");
  oe_pair_a: assert property (bus_oe_o[0] |-> !serial_result_out_oe_o)
    else $error("bus and serial both driven");
  sdo_oe_a: assert property (settled_s |-> serial_result_out_oe_o == $past(ctl_q[2]))
    else $error("serial enable wrong");
  sclk_oe_a: assert property (settled_s |-> sclk_oe_o == $past(mst))
    else $error("clock enable wrong");
  sclk_per_a: assert property ($rose(sclk_o) && sclk_oe_o && gap_q < 6'd40 |-> gap_q == per)
    else $error("serial clock period wrong");
  rac_msb_a: assert property (mst && !ctl_q[4] && conv_done_i && gap_q > 6'd40
    |-> ##[1:3] serial_result_out_o == (result_i[WIDTH-1] ^ ~ctl_q[1]))
    else $error("first bit after convert wrong");
  dur_msb_a: assert property (mst && ctl_q[4] && have_q && conv_start_i && gap_q > 6'd40
    |-> ##[1:3] serial_result_out_o == (raw_q[15] ^ ~ctl_q[1]))
    else $error("first bit during convert wrong");
endmodule
`default_nettype wire

// file: aop_host.sv
`timescale 1ns/1ps
`default_nettype none
module aop_host (
  // Clock and bench control
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic ext_run_i,
  input wire logic [1:0] div_i,
  // Device pins
  input wire logic [15:0] dev_bus_i,
  input wire logic [15:0] dev_oe_i,
  input wire logic dev_sclk_i,
  input wire logic dev_sclk_oe_i,
  input wire logic sdo_i,
  output logic [15:0] pin_o,
  output logic hclk_o,
  // Collected word
  output logic [15:0] word_o,
  output logic [4:0] cnt_o
);
  logic sc_q = 1'b0;
  logic [1:0] ph_q = 2'h0;
  logic wire_sclk;
  initial hclk_o = 1'b0;
  initial cnt_o = 5'h00;
  initial word_o = 16'h0000;
  // Floating pins show the inverse of the last value, except pins 3 and 2, which carry the divider code
  always_comb begin
    pin_o = ~(dev_bus_i ^ dev_oe_i);
    if (!dev_oe_i[2]) begin
      pin_o[3:2] = div_i;
    end
  end
  assign wire_sclk = dev_sclk_oe_i ? dev_sclk_i : hclk_o;
  always @(posedge clk_i) begin
    sc_q <= wire_sclk;
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    if (clr_i) begin
      cnt_o <= 5'h00;
    end else if (wire_sclk && !sc_q && cnt_o < 5'd16) begin
      word_o <= {word_o[14:0], sdo_i};
      cnt_o <= cnt_o + 5'h01;
    end
    // Host clock stands low outside frames
    if (ph_q == 2'h2) begin
      hclk_o <= ext_run_i && cnt_o < 5'd16 && !hclk_o;
    end
  end
endmodule
`default_nettype wire

// file: aop_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module aop_port_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, sclk_i, sclk_o, sclk_oe, sdo, sdo_oe;
  logic conv_start_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [15:0] result_i = 16'h0;
  logic [15:0] bus_i, bus_o, bus_oe, word;
  logic clr = 1'b1;
  logic ext_run = 1'b0;
  logic [1:0] div = 2'h0;
  logic [4:0] cnt;
  logic [31:0] seed = 32'hb824beef;
  logic [15:0] sent_q[$];
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  aop_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
    .result_i(result_i), .bus_i(bus_i), .bus_o(bus_o), .bus_oe_o(bus_oe), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .serial_result_out_o(sdo),
    .serial_result_out_oe_o(sdo_oe));
  aop_host host_u (.clk_i(clk_i), .clr_i(clr), .ext_run_i(ext_run), .div_i(div),
    .dev_bus_i(bus_o), .dev_oe_i(bus_oe), .dev_sclk_i(sclk_o), .dev_sclk_oe_i(sclk_oe),
    .sdo_i(sdo), .pin_o(bus_i), .hclk_o(sclk_i), .word_o(word), .cnt_o(cnt));
  // ****
  // Helpers
  // ****
  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic conv(input logic [15:0] v);
    conv_start_i <= 1'b1;
    @(posedge clk_i);
    conv_start_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    result_i <= v;
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] r, input logic [4:0] c);
    logic [15:0] k;
    k = r ^ {~c[1], 15'h0000};
    return c[0] ? {k[7:0], k[15:8]} : k;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // ****
  // Sequence
  // ****
  initial begin
    logic [4:0] c;
    logic [15:0] v;
    logic [15:0] last;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl reset", rd, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    check("ro write", 32'(err), 32'h1);
    for (int i = 0; i < 4; i++) begin
      c = {3'h0, i[1:0]};
      apb(1'b1, 12'h000, 32'(c));
      seed = xs(seed);
      v = seed[15:0];
      conv(v);
      last = v;
      check("bus word", 32'(bus_o), 32'(fmt(v, c)));
      check("bus drive", 32'(bus_oe), 32'hffff);
      apb(1'b0, 12'h008, 32'h0);
      check("result reg", rd, 32'(fmt(v, c)));
      apb(1'b0, 12'h00c, 32'h0);
      check("coded reg", rd, 32'(fmt(v, c & 5'h1e)));
    end
    apb(1'b1, 12'h000, 32'h0);
    // Pins are registered, so the new coding shows one edge after the write
    @(posedge clk_i);
    check("reformat", 32'(bus_o), 32'(fmt(last, 5'h00)));
    // Four divider codes, then during-convert and host-clocked frames
    for (int j = 0; j < 6; j++) begin
      c = (j == 4) ? 5'h16 : (j == 5) ? 5'h0e : {2'h0, 1'b1, j[0], 1'b0};
      div <= (j < 4) ? j[1:0] : 2'h3;
      clr <= 1'b1;
      apb(1'b1, 12'h000, 32'(c));
      clr <= 1'b0;
      @(posedge clk_i);
      check("serial bus", 32'(bus_oe), 32'h0);
      check("serial drive", 32'({sdo_oe, sclk_oe}), 32'({1'b1, j < 5}));
      seed = xs(seed);
      v = seed[15:0];
      sent_q.push_back((j == 4) ? last : v);
      conv(v);
      ext_run <= (j == 5);
      for (int k = 0; k < 2000 && cnt != 5'd16; k++) @(posedge clk_i);
      check("serial count", 32'(cnt), 32'h10);
      check("serial word", 32'(word), 32'(fmt(sent_q.pop_front(), c)));
      last = v;
      ext_run <= 1'b0;
      repeat (60) @(posedge clk_i);
      apb(1'b0, 12'h004, 32'h0);
      check("status", rd, 32'({1'b1, j == 4, j < 4, j < 5, 1'b1, 1'b0, div}));
    end
    summarize();
  end
endmodule
bind aop_port aop_port_monitor #(.WIDTH(WIDTH)) mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .conv_start_i(conv_start_i), .conv_done_i(conv_done_i), .result_i(result_i),
  .bus_i(bus_i), .bus_o(bus_o), .bus_oe_o(bus_oe_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
  .serial_result_out_o(serial_result_out_o), .serial_result_out_oe_o(serial_result_out_oe_o));
`default_nettype wire
